// ---- cond_branch_defines.vh ----
// constants for the conditional branch decode and execute unit
`ifndef COND_BRANCH_DEFINES_VH
`define COND_BRANCH_DEFINES_VH

// ==========================================================================
// instruction fields
`define OPC_HI            31
`define OPC_LO            26
`define SRCA_HI           25
`define SRCA_LO           21
`define SRCB_HI           20
`define SRCB_LO           16
`define OFFS_HI           15
`define OFFS_LO           0

// ==========================================================================
// encodings
`define OPC_REG_IMM_GROUP 6'h01
`define OPC_NOT_EQUAL     6'h05
`define SUB_NEG_LINK      5'h10
`define SUB_NEG_LINK_LIK  5'h12
`define SUB_NEG_LIKELY    5'h02
`define LINK_REG          5'h1f
`define ZERO_REG          5'h00

// ==========================================================================
// address arithmetic
`define INSTR_BYTES       4'h4
`define LINK_BYTES        4'h8
`define OFFS_SHIFT        2

`endif

// ---- cond_branch_link_likely_unit.v ----
// decode and execute of negative-link, likely and not-equal branches
// How it works
// - decode negative-link: group 000001, sub 10000
// - decode negative-link-likely: sub code 10010
// - decode negative-likely, no link: sub 00010
// - decode not-equal from opcode 000101
// - target = delay slot address + offset*4
// - negative means sign bit of register set
// - not-equal taken when registers differ
// - link forms write register 31 with pc+8
// - plain forms run delay slot, then redirect
// - likely forms nullify delay slot when untaken
// - newer release keeps only source-zero link and not-equal
// - likely forms predicted taken, tables untouched
// - branches raise no exception, legacy and newer-release modes excepted
// - newer release traps transfers in delay slots
`timescale 1ns/1ps
`include "cond_branch_defines.vh"

module cond_branch_link_likely_unit
#(
  parameter XLEN = 64
)
(
  input  wire            clock_in,
  input  wire            arst_n_in,
  input  wire            enable_in,
  input  wire            issue_valid_in,
  input  wire [31:0]     instr_in,
  input  wire [XLEN-1:0] pc_in,
  input  wire [XLEN-1:0] source_reg_a_in,
  input  wire [XLEN-1:0] source_reg_b_in,
  input  wire            release6_mode_in,
  input  wire            legacy_mode_in,
  output reg  [4:0]      src_a_index_out,
  output reg  [4:0]      src_b_index_out,
  output reg             link_write_out,
  output reg  [4:0]      link_index_out,
  output reg  [XLEN-1:0] link_value_out,
  output reg             redirect_out,
  output reg  [XLEN-1:0] redirect_pc_out,
  output reg             nullify_out,
  output reg             predict_taken_out,
  output reg             predictor_bypass_out,
  output reg             reserved_instr_out,
  output reg             branch_seen_out
);

  // ==========================================================================
  // decode
  wire [5:0] opc  = instr_in[`OPC_HI:`OPC_LO];
  wire [4:0] srca = instr_in[`SRCA_HI:`SRCA_LO];
  wire [4:0] srcb = instr_in[`SRCB_HI:`SRCB_LO];
  wire [15:0] offs = instr_in[`OFFS_HI:`OFFS_LO];

  wire grp         = (opc == `OPC_REG_IMM_GROUP);
  wire is_neg_link = grp && (srcb == `SUB_NEG_LINK);
  wire is_nl_lik   = grp && (srcb == `SUB_NEG_LINK_LIK);
  wire is_neg_lik  = grp && (srcb == `SUB_NEG_LIKELY);
  wire is_ne       = (opc == `OPC_NOT_EQUAL);
  wire is_branch   = is_neg_link | is_nl_lik | is_neg_lik | is_ne;
  wire is_likely   = is_nl_lik | is_neg_lik;
  wire is_link     = is_neg_link | is_nl_lik;

  // in the newer release only the source-zero link form and not-equal survive
  wire r6_dropped = release6_mode_in &&
                    (is_likely || (is_neg_link && srca != `ZERO_REG));
  // first-generation cores trapped the likely forms
  wire legacy_trap = legacy_mode_in && is_likely;
  wire illegal = r6_dropped | legacy_trap;

  // ==========================================================================
  // condition and target
  wire negative = source_reg_a_in[XLEN-1];
  wire differ   = (source_reg_a_in != source_reg_b_in);
  // source-zero link form is never taken: register zero reads as zero, so only the link happens
  wire cond = is_ne ? differ : negative;

  wire [17:0]     offs18  = {offs, 2'b00};
  wire [XLEN-1:0] offs_x  = {{(XLEN-18){offs18[17]}}, offs18};
  // steps widened on purpose so the sums stay at register width
  wire [XLEN-1:0] slot_step = {{(XLEN-4){1'b0}}, `INSTR_BYTES};
  wire [XLEN-1:0] link_step = {{(XLEN-4){1'b0}}, `LINK_BYTES};
  wire [XLEN-1:0] slot_pc   = pc_in + slot_step;
  wire [XLEN-1:0] target    = slot_pc + offs_x;
  wire [XLEN-1:0] link_pc   = pc_in + link_step;

  wire fire = issue_valid_in && is_branch && !illegal;

  // ==========================================================================
  // delay-slot tracking
  // a taken redirect is held until the delay slot instruction has issued;
  // the slot state also remembers whether the slot must be cancelled
  localparam [1:0] SLOT_IDLE    = 2'b00;
  localparam [1:0] SLOT_TAKEN   = 2'b01;
  localparam [1:0] SLOT_FALL    = 2'b10;
  localparam [1:0] SLOT_NULLIFY = 2'b11;

  // only this unit's own forms are seen here; other transfers are caught by the core's wider decode
  wire slot_trap = release6_mode_in && is_branch;

  // slot state entered once a legal branch is accepted
  wire [1:0] accept_state = cond      ? SLOT_TAKEN   :
                            is_likely ? SLOT_NULLIFY :
                                        SLOT_FALL;

  reg  [1:0]      state_q;
  reg  [1:0]      state_d;
  reg  [XLEN-1:0] pend_target_q;
  reg  [XLEN-1:0] pend_target_d;
  reg             link_write_d;
  reg  [4:0]      link_index_d;
  reg  [XLEN-1:0] link_value_d;
  reg             redirect_d;
  reg  [XLEN-1:0] redirect_pc_d;
  reg             nullify_d;
  reg             predict_taken_d;
  reg             predictor_bypass_d;
  reg             reserved_instr_d;
  reg             branch_seen_d;

  // ==========================================================================
  // next state and next outputs
  always @*
  begin
    state_d            = state_q;
    pend_target_d      = pend_target_q;
    link_write_d       = 1'b0;
    link_index_d       = link_index_out;
    link_value_d       = link_value_out;
    redirect_d         = 1'b0;
    redirect_pc_d      = redirect_pc_out;
    nullify_d          = 1'b0;
    predict_taken_d    = 1'b0;
    predictor_bypass_d = 1'b0;
    reserved_instr_d   = 1'b0;
    branch_seen_d      = 1'b0;
    if (issue_valid_in)
    begin
      case (state_q)
        SLOT_IDLE:
        begin
          if (illegal)
            reserved_instr_d = 1'b1;
          else if (fire)
          begin
            branch_seen_d = 1'b1;
            state_d       = accept_state;
            pend_target_d = target;
            if (is_link)
            begin
              // written whether or not the branch is taken
              link_write_d = 1'b1;
              link_index_d = `LINK_REG;
              link_value_d = link_pc;
            end
            if (is_likely)
            begin
              predict_taken_d    = 1'b1;
              predictor_bypass_d = 1'b1;
            end
          end
        end
        SLOT_TAKEN:
        begin
          // the slot has issued, so fetch may now go to the target
          state_d          = SLOT_IDLE;
          redirect_d       = 1'b1;
          redirect_pc_d    = pend_target_q;
          reserved_instr_d = slot_trap;
        end
        SLOT_FALL:
        begin
          state_d          = SLOT_IDLE;
          reserved_instr_d = slot_trap;
        end
        SLOT_NULLIFY:
        begin
          // a cancelled slot never runs, so it is never trapped either
          state_d   = SLOT_IDLE;
          nullify_d = 1'b1;
        end
        default:
          state_d = SLOT_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // registers, each frozen while the clock enable is low
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q       <= SLOT_IDLE;
      pend_target_q <= {XLEN{1'b0}};
    end
    else if (enable_in)
    begin
      state_q       <= state_d;
      pend_target_q <= pend_target_d;
    end
  end

  // source field copies for the register file read ports
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      src_a_index_out <= 5'h00;
      src_b_index_out <= 5'h00;
    end
    else if (enable_in)
    begin
      src_a_index_out <= srca;
      src_b_index_out <= srcb;
    end
  end

  // link write strobe
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      link_write_out <= 1'b0;
    end
    else if (enable_in)
    begin
      link_write_out <= link_write_d;
    end
  end

  // link index and value hold until the next link form
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      link_index_out <= 5'h00;
      link_value_out <= {XLEN{1'b0}};
    end
    else if (enable_in)
    begin
      link_index_out <= link_index_d;
      link_value_out <= link_value_d;
    end
  end

  // fetch redirect and its target
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      redirect_out    <= 1'b0;
      redirect_pc_out <= {XLEN{1'b0}};
    end
    else if (enable_in)
    begin
      redirect_out    <= redirect_d;
      redirect_pc_out <= redirect_pc_d;
    end
  end

  // delay-slot cancel
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nullify_out <= 1'b0;
    end
    else if (enable_in)
    begin
      nullify_out <= nullify_d;
    end
  end

  // prediction hints for the likely forms
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      predict_taken_out    <= 1'b0;
      predictor_bypass_out <= 1'b0;
    end
    else if (enable_in)
    begin
      predict_taken_out    <= predict_taken_d;
      predictor_bypass_out <= predictor_bypass_d;
    end
  end

  // reserved-instruction exception
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reserved_instr_out <= 1'b0;
    end
    else if (enable_in)
    begin
      reserved_instr_out <= reserved_instr_d;
    end
  end

  // acceptance strobe
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      branch_seen_out <= 1'b0;
    end
    else if (enable_in)
    begin
      branch_seen_out <= branch_seen_d;
    end
  end

endmodule

// ---- cond_branch_chk.sv ----
// checker for the conditional branch unit
`timescale 1ns/1ps
module cond_branch_chk
#(
  parameter XLEN = 64
)
(
  input wire logic            clock_in,
  input wire logic            arst_n_in,
  input wire logic            enable_in,
  input wire logic            issue_valid_in,
  input wire logic            release6_mode_in,
  input wire logic            legacy_mode_in,
  input wire logic [31:0]     instr_in,
  input wire logic [XLEN-1:0] pc_in,
  input wire logic [XLEN-1:0] source_reg_a_in,
  input wire logic [XLEN-1:0] source_reg_b_in,
  input wire logic [XLEN-1:0] link_value_out,
  input wire logic [4:0]      link_index_out,
  input wire logic            link_write_out,
  input wire logic            redirect_out,
  input wire logic            nullify_out,
  input wire logic            predictor_bypass_out,
  input wire logic            reserved_instr_out,
  input wire logic            branch_seen_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // the delay slot follows at once in the bench, so a pending branch shows as branch_seen_out
  wire       i = enable_in && issue_valid_in && !branch_seen_out;
  wire       o = !release6_mode_in;
  // legacy cores trap the likely forms, so their normal behaviour is only expected outside it
  wire       l = !legacy_mode_in;
  wire       g = instr_in[31:26] == 6'h01;
  wire       ne = instr_in[31:26] == 6'h05;
  wire [4:0] sb = instr_in[20:16];
  wire       ng = source_reg_a_in[XLEN-1];
  sequence s_ds; enable_in && issue_valid_in; endsequence
  property p_link; i && o && g && sb == 5'h10 |=> link_write_out && link_index_out == 5'h1f
    && link_value_out == $past(pc_in) + 8; endproperty
  a_link: assert property (p_link) else $error("link write wrong");
  property p_lik; i && o && l && g && sb == 5'h02 |=> !link_write_out && predictor_bypass_out; endproperty
  a_lik: assert property (p_lik) else $error("likely decode wrong");
  property p_ne; i && ne |=> branch_seen_out && !link_write_out; endproperty
  a_ne: assert property (p_ne) else $error("not-equal decode wrong");
  property p_tkn; i && o && g && sb == 5'h10 && ng ##1 s_ds |=> redirect_out; endproperty
  a_tkn: assert property (p_tkn) else $error("negative not taken");
  property p_eq; i && ne && source_reg_a_in == source_reg_b_in ##1 s_ds |=> !redirect_out; endproperty
  a_eq: assert property (p_eq) else $error("equal taken");
  property p_nul; i && o && l && g && sb == 5'h02 && !ng ##1 s_ds |=> nullify_out && !redirect_out; endproperty
  a_nul: assert property (p_nul) else $error("slot not nullified");
  property p_r6; i && !o && g && sb == 5'h12 |=> reserved_instr_out && !link_write_out; endproperty
  a_r6: assert property (p_r6) else $error("dropped form accepted");
  property p_ds; enable_in && issue_valid_in && !o && branch_seen_out && ne |=> reserved_instr_out; endproperty
  a_ds: assert property (p_ds) else $error("slot branch not trapped");
endmodule
bind cond_branch_link_likely_unit cond_branch_chk #(.XLEN(XLEN)) u_chk (.clock_in, .arst_n_in, .enable_in,
  .issue_valid_in, .release6_mode_in, .legacy_mode_in, .instr_in, .pc_in, .source_reg_a_in, .source_reg_b_in,
  .link_value_out,
  .link_index_out, .link_write_out, .redirect_out, .nullify_out, .predictor_bypass_out, .reserved_instr_out,
  .branch_seen_out);

// ---- cond_branch_link_likely_unit_tb.sv ----
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
module cond_branch_link_likely_unit_tb;
  logic clock_in = 0, arst_n_in = 0, en = 1, iv = 0, r6 = 0, lg = 0;
  logic [31:0] ins = 0;
  logic [63:0] pc = 0, a = 0, b = 0;
  wire  [63:0] lv, rp;
  wire         lw, rd, nl, pt, pb, ri, bs;
  wire  [4:0]  xa, xb, li;
  integer      n_fail = 0, compares = 0;
  localparam logic [63:0] P = 64'h1000, M = 64'h8000_0000_0000_0000;
  always #5 clock_in = ~clock_in;
  cond_branch_link_likely_unit DUT (.clock_in, .arst_n_in, .enable_in(en), .issue_valid_in(iv), .instr_in(ins),
    .pc_in(pc), .source_reg_a_in(a), .source_reg_b_in(b), .release6_mode_in(r6), .legacy_mode_in(lg),
    .src_a_index_out(xa), .src_b_index_out(xb), .link_write_out(lw), .link_index_out(li), .link_value_out(lv),
    .redirect_out(rd), .redirect_pc_out(rp), .nullify_out(nl), .predict_taken_out(pt),
    .predictor_bypass_out(pb), .reserved_instr_out(ri), .branch_seen_out(bs));
  // ==================================================
  // helpers
  task close_out;
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // negative offset: target lands below the branch, P + 4 - 8
  function logic [31:0] br(input logic [5:0] o, input logic [4:0] s);
    br = {o, 5'h03, s, 16'hfffe};
  endfunction
  task run(input logic [31:0] bi, di, input logic [63:0] va, vb, input logic [4:0] e1, input logic [2:0] e2);
    @(negedge clock_in);
    {iv, ins, pc, a, b} = {1'b1, bi, P, va, vb};
    @(negedge clock_in);
    chk({lw, ri, pt, pb, bs}, e1);
    chk({xa, xb}, {bi[25:21], bi[20:16]});
    if (e1[4]) chk(lv, P + 8);
    if (e1[4]) chk(li, 5'h1f);
    {ins, pc} = {di, P + 64'h4};
    @(negedge clock_in);
    iv = 0;
    chk({rd, nl, ri}, e2);
    if (e2[2]) chk(rp, P - 64'h4);
  endtask
  // ==================================================
  // scenarios
  task t_link;
    run(br(6'h01, 5'h10), 0, M, 0, 5'b10001, 3'b100);
    run(br(6'h01, 5'h10), 0, ~M, 0, 5'b10001, 3'b000);
  endtask
  task t_likely;
    run(br(6'h01, 5'h12), 0, M, 0, 5'b10111, 3'b100);
    run(br(6'h01, 5'h12), 0, ~M, 0, 5'b10111, 3'b010);
    run(br(6'h01, 5'h02), 0, M, 0, 5'b00111, 3'b100);
    run(br(6'h01, 5'h02), 0, 0, 0, 5'b00111, 3'b010);
  endtask
  task t_ne;
    run(br(6'h05, 5'h04), 0, M, 0, 5'b00001, 3'b100);
    run(br(6'h05, 5'h04), 0, M, M, 5'b00001, 3'b000);
  endtask
  task t_r6;
    r6 = 1;
    run(br(6'h01, 5'h12), 0, M, 0, 5'b01000, 3'b000);
    run(br(6'h01, 5'h02), 0, M, 0, 5'b01000, 3'b000);
    run(br(6'h01, 5'h10), 0, M, 0, 5'b01000, 3'b000);
    run({6'h01, 5'h00, 5'h10, 16'hfffe}, 0, 0, 0, 5'b10001, 3'b000);
    run(br(6'h05, 5'h04), br(6'h05, 5'h04), M, M, 5'b00001, 3'b001);
    r6 = 0;
  endtask
  task t_leg;
    lg = 1;
    run(br(6'h01, 5'h12), 0, M, 0, 5'b01000, 3'b000);
    run(br(6'h01, 5'h02), 0, M, 0, 5'b01000, 3'b000);
    run(br(6'h05, 5'h04), 0, M, 0, 5'b00001, 3'b100);
    lg = 0;
  endtask
  // clock enable low: nothing is taken and branch_seen_out and redirect_out hold
  task t_en;
    @(negedge clock_in);
    {en, iv, ins, pc, a, b} = {1'b0, 1'b1, br(6'h01, 5'h10), P, M, 64'h0};
    @(negedge clock_in);
    chk(bs, 0);
    en = 1;
    @(negedge clock_in);
    chk(bs, 1);
    {en, ins, pc} = {1'b0, 32'h0, P + 64'h4};
    @(negedge clock_in);
    chk({bs, rd}, 2'b10);
    en = 1;
    @(negedge clock_in);
    iv = 0;
    chk({bs, rd}, 2'b01);
  endtask
  initial
  begin
    repeat (20) @(negedge clock_in);
    arst_n_in = 1;
    t_link;
    t_likely;
    t_ne;
    t_r6;
    t_leg;
    t_en;
    close_out;
  end
  initial
  begin
    #20000;
    n_fail++;
    close_out;
  end
endmodule
